/* File: hdl/epvu_core.sv */
// Purpose: picks the winning pending exception, decides preemption, forms vector address
// Assumes: core acknowledges entry with enter_ack and signals return with exc_return
// Notes:   nesting depth tracked by an active bitmap; running priority is the best active
//
// Functional notes
// [R1] interrupt n is exception n plus 16, vectors from offset 0x40, four bytes apart
// [R2] entry zero holds stack pointer; exception n vector sits at base plus 4n
// [R3] software sets handler address bit zero to mark compact instruction state
// [R4] after reset the table base is zero until relocated
// [R5] privileged write relocates base within 0x100 to 0x3fffff00
// [R6] software aligns base to 256 bytes; low eight bits forced zero
// [R7] lower priority value wins; reset, hard fault, nmi are fixed
// [R8] configurable priorities reset to zero
// [R9] configurable priorities lie in 0 to 7, below fixed negatives
// [R10] equal priorities resolve to lowest exception number
// [R11] strictly higher priority arrival preempts the active handler
// [R12] equal priority arrival never preempts the active handler
// [R13] equal priority arrival is still recorded as pending
// [R14] nmi has fixed priority -2 and cannot be masked
// [R15] hard fault has fixed priority -1
// [R16] each exception is inactive, pending, active, or active and pending
// [R17] priorities stored in three bits, compared signed so negatives win
// [R18] interrupt numbers without a source stay inactive and never win
`timescale 1ns/1ps
`default_nettype none
module epvu_core
    import epvu_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          resetn,
    input  wire logic                          clk_en,
    input  wire logic [EPVU_NUM_IRQ-1:0]       irq_req,
    input  wire logic [15:0]                   sys_req,
    input  wire logic                          pri_wr,
    input  wire logic [5:0]                    pri_wr_num,
    input  wire logic [2:0]                    pri_wr_val,
    input  wire logic                          base_wr,
    input  wire logic                          base_wr_priv,
    input  wire logic [31:0]                   base_wr_val,
    input  wire logic                          enter_ack,
    input  wire logic                          exc_return,
    output logic                               vec_valid,
    output logic                               vec_preempt,
    output logic [5:0]                         vec_num,
    output logic [31:0]                        vec_addr,
    output logic [31:0]                        vector_base_offset_reg,
    output logic [EPVU_NUM_EXC-1:0]            pend_out,
    output logic [EPVU_NUM_EXC-1:0]            active_out,
    output logic signed [3:0]                  run_pri
);
    logic [2:0]            pri_q [EPVU_NUM_EXC];
    logic [EPVU_NUM_EXC-1:0] pend_q;
    logic [EPVU_NUM_EXC-1:0] act_q;
    logic [EPVU_NUM_EXC-1:0] present;
    logic [EPVU_NUM_EXC-1:0] req_now;
    logic [31:0]           base_q;
    epvu_state_e           state_q;
    epvu_cand_s            best;
    epvu_cand_s            run;
    epvu_vec_s             vec_q;
    logic                  take;

    // fixed exceptions get negative priorities, others their stored field
    function automatic logic signed [3:0] eff_pri(input logic [5:0] n, input logic [2:0] p);
        if (n == EPVU_EXC_NMI) begin
            return EPVU_PRI_NMI; // R14
        end else if (n == EPVU_EXC_HARD) begin
            return EPVU_PRI_HARD; // R15
        end
        return $signed({1'b0, p}); // R17
    endfunction : eff_pri

    function automatic logic [31:0] vec_of(input logic [31:0] b, input logic [5:0] n);
        return b + {24'h0, n, 2'b00}; // R2
    endfunction : vec_of

    assign present = {EPVU_IRQ_PRESENT, EPVU_SYS_PRESENT};
    assign req_now = {irq_req, sys_req} & present; // R18

    // strict less-than scanning upward keeps the lowest number on ties
    always_comb begin
        best = '{valid: 1'b0, num: 6'h0, pri: EPVU_PRI_IDLE};
        run  = '{valid: 1'b0, num: 6'h0, pri: EPVU_PRI_IDLE};
        for (int i = 2; i < EPVU_NUM_EXC; i++) begin
            if (pend_q[i] && present[i] && !act_q[i] &&
                (!best.valid || eff_pri(6'(i), pri_q[i]) < best.pri)) begin // R7 R10
                best = '{valid: 1'b1, num: 6'(i), pri: eff_pri(6'(i), pri_q[i])};
            end
            if (act_q[i] && (!run.valid || eff_pri(6'(i), pri_q[i]) < run.pri)) begin
                run = '{valid: 1'b1, num: 6'(i), pri: eff_pri(6'(i), pri_q[i])};
            end
        end
    end

    // checker helper: any eligible candidate that should have beaten the winner
    logic order_bad;
    always_comb begin
        order_bad = 1'b0;
        for (int j = 2; j < EPVU_NUM_EXC; j++) begin
            if (best.valid && pend_q[j] && present[j] && !act_q[j]) begin
                if (eff_pri(6'(j), pri_q[j]) < best.pri ||
                    (eff_pri(6'(j), pri_q[j]) == best.pri && 6'(j) < best.num)) begin
                    order_bad = 1'b1;
                end
            end
        end
    end

    // strictly better than running priority; equal never preempts
    assign take = best.valid && (!run.valid || best.pri < run.pri); // R11 R12

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < EPVU_NUM_EXC; i++) begin
                pri_q[i] <= EPVU_PRI_RESET; // R8
            end
        end else if (clk_en && pri_wr && pri_wr_num < 6'(EPVU_NUM_EXC)) begin
            pri_q[pri_wr_num] <= pri_wr_val; // R9
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            base_q <= EPVU_BASE_RESET; // R4
        end else if (clk_en && base_wr && base_wr_priv &&
                     {base_wr_val[31:8], 8'h00} >= EPVU_BASE_MIN &&
                     {base_wr_val[31:8], 8'h00} <= EPVU_BASE_MAX) begin
            base_q <= {base_wr_val[31:8], 8'h00}; // R5 R6
        end
    end

    // requests set pending even when they cannot preempt
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_q <= '0;
            act_q  <= '0;
        end else if (clk_en) begin
            pend_q <= (pend_q & ~((state_q == EPVU_ENTER && enter_ack) ?
                      (60'h1 << vec_q.num) : 60'h0)) | req_now; // R13 R16
            if (state_q == EPVU_ENTER && enter_ack) begin
                act_q[vec_q.num] <= 1'b1; // R16
            end else if (exc_return && run.valid) begin
                act_q[run.num] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= EPVU_IDLE;
            vec_q   <= '0;
        end else if (clk_en) begin
            unique case (state_q)
                EPVU_IDLE, EPVU_ACTIVE: begin
                    if (take) begin
                        state_q       <= EPVU_ENTER;
                        vec_q.take    <= 1'b1;
                        vec_q.preempt <= run.valid;
                        vec_q.num     <= best.num;
                        vec_q.addr    <= vec_of(base_q, best.num); // R1
                    end else begin
                        vec_q.take <= 1'b0;
                        state_q    <= (|act_q) ? EPVU_ACTIVE : EPVU_IDLE;
                    end
                end
                EPVU_ENTER: begin
                    if (enter_ack) begin
                        state_q    <= EPVU_ACTIVE;
                        vec_q.take <= 1'b0;
                    end
                end
                default: state_q <= EPVU_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vec_valid              <= 1'b0;
            vec_preempt            <= 1'b0;
            vec_num                <= 6'h0;
            vec_addr               <= 32'h0;
            vector_base_offset_reg <= EPVU_BASE_RESET;
            pend_out               <= '0;
            active_out             <= '0;
            run_pri                <= EPVU_PRI_IDLE;
        end else if (clk_en) begin
            vec_valid              <= vec_q.take;
            vec_preempt            <= vec_q.preempt;
            vec_num                <= vec_q.num;
            vec_addr               <= vec_q.addr;
            vector_base_offset_reg <= base_q;
            pend_out               <= pend_q;
            active_out             <= act_q;
            run_pri                <= run.pri;
        end
    end

    AST_IRQ_VEC: assert property (@(posedge clk) disable iff (!resetn) // R1
        vec_q.take && vec_q.num >= EPVU_IRQ_BASE |-> vec_q.addr[7:0] == {vec_q.num, 2'b00})
        else $error("vector address not four times the exception number");
    AST_BASE_RANGE: assert property (@(posedge clk) disable iff (!resetn) // R5
        base_q == EPVU_BASE_RESET || (base_q >= EPVU_BASE_MIN && base_q <= EPVU_BASE_MAX))
        else $error("table base out of range");
    AST_BASE_ALIGN: assert property (@(posedge clk) disable iff (!resetn) // R6
        base_q[7:0] == 8'h00) else $error("table base misaligned");
    AST_NO_EQ_PREEMPT: assert property (@(posedge clk) disable iff (!resetn) // R12
        clk_en && state_q != EPVU_ENTER && run.valid && best.pri >= run.pri |=> !(state_q == EPVU_ENTER && $changed(vec_q.num) && vec_q.preempt))
        else $error("equal priority preempted");
    AST_PREEMPT: assert property (@(posedge clk) disable iff (!resetn) // R11
        clk_en && state_q == EPVU_ACTIVE && run.valid && take |=> state_q == EPVU_ENTER && vec_q.preempt)
        else $error("higher priority did not preempt");
    AST_PEND_REC: assert property (@(posedge clk) disable iff (!resetn) // R13
        clk_en && req_now[EPVU_NUM_EXC-1] |=> pend_q[EPVU_NUM_EXC-1])
        else $error("request not recorded as pending");
    AST_RSVD: assert property (@(posedge clk) disable iff (!resetn) // R18
        (pend_q & ~present) == '0 && !(vec_q.take && !present[vec_q.num]))
        else $error("reserved slot became pending or won");
    AST_NMI_WINS: assert property (@(posedge clk) disable iff (!resetn) // R14
        pend_q[EPVU_EXC_NMI] && !act_q[EPVU_EXC_NMI] |-> best.num == EPVU_EXC_NMI)
        else $error("nmi lost arbitration");
    AST_OUT_LAG: assert property (@(posedge clk) disable iff (!resetn) // R1
        clk_en && vec_q.take |=> vec_valid)
        else $error("vector output missing");
    AST_ORDER: assert property (@(posedge clk) disable iff (!resetn) // R7 R10
        best.valid |-> !order_bad)
        else $error("winner not the best ranked pending exception");
    AST_FIXED_PRI: assert property (@(posedge clk) disable iff (!resetn) // R15
        eff_pri(EPVU_EXC_NMI, pri_q[EPVU_EXC_NMI]) == EPVU_PRI_NMI &&
        eff_pri(EPVU_EXC_HARD, pri_q[EPVU_EXC_HARD]) == EPVU_PRI_HARD)
        else $error("fixed priority altered");
    AST_HARD_WINS: assert property (@(posedge clk) disable iff (!resetn) // R15
        pend_q[EPVU_EXC_HARD] && !act_q[EPVU_EXC_HARD] &&
        !(pend_q[EPVU_EXC_NMI] && !act_q[EPVU_EXC_NMI]) |-> best.num == EPVU_EXC_HARD)
        else $error("hard fault lost arbitration");
    AST_NMI_KEEP: assert property (@(posedge clk) disable iff (!resetn) // R14
        act_q[EPVU_EXC_NMI] |-> !take)
        else $error("nmi handler preempted");
    AST_CFG_RANGE: assert property (@(posedge clk) disable iff (!resetn) // R9
        best.valid && best.num > EPVU_EXC_HARD |-> best.pri >= 4'sd0)
        else $error("configurable priority went negative");
    AST_PRI_WR: assert property (@(posedge clk) disable iff (!resetn) // R9
        clk_en && pri_wr && pri_wr_num < 6'(EPVU_NUM_EXC)
        |=> pri_q[$past(pri_wr_num)] == $past(pri_wr_val))
        else $error("priority write lost");
    AST_BASE_PRIV: assert property (@(posedge clk) disable iff (!resetn) // R5
        clk_en && base_wr && !base_wr_priv |=> $stable(base_q))
        else $error("unprivileged relocation accepted");
    AST_ACK_ACTIVE: assert property (@(posedge clk) disable iff (!resetn) // R16
        clk_en && state_q == EPVU_ENTER && enter_ack |=> act_q[$past(vec_q.num)])
        else $error("accepted exception not active");
    AST_ACK_CLEARS: assert property (@(posedge clk) disable iff (!resetn) // R16
        clk_en && state_q == EPVU_ENTER && enter_ack && !req_now[vec_q.num]
        |=> !pend_q[$past(vec_q.num)])
        else $error("accepted exception still pending");
    AST_RETURN: assert property (@(posedge clk) disable iff (!resetn) // R16
        clk_en && exc_return && run.valid && !(state_q == EPVU_ENTER && enter_ack)
        |=> !act_q[$past(run.num)])
        else $error("returned handler still active");
    AST_ENTER_HOLD: assert property (@(posedge clk) disable iff (!resetn) // R1
        clk_en && state_q == EPVU_ENTER && !enter_ack |=> state_q == EPVU_ENTER && $stable(vec_q.num))
        else $error("presented vector withdrawn before acceptance");
    AST_IRQ_OFS: assert property (@(posedge clk) disable iff (!resetn) // R1
        vec_q.take && vec_q.num >= EPVU_IRQ_BASE |-> vec_q.addr[7:0] >= 8'h40)
        else $error("interrupt vector below interrupt area");
    AST_OUT_MATCH: assert property (@(posedge clk) disable iff (!resetn) // R1
        clk_en && vec_q.take |=> vec_num == $past(vec_q.num) && vec_addr == $past(vec_q.addr))
        else $error("vector outputs differ from chosen entry");
    AST_RUN_IDLE: assert property (@(posedge clk) disable iff (!resetn) // R17
        !(|act_q) |-> run.pri == EPVU_PRI_IDLE)
        else $error("running priority wrong while idle");
    AST_FREEZE: assert property (@(posedge clk) disable iff (!resetn)
        !clk_en |=> $stable(pend_q) && $stable(act_q) && $stable(state_q))
        else $error("state moved while clock enable low");
    AST_ONEHOT: assert property (@(posedge clk) disable iff (!resetn)
        $onehot(state_q))
        else $error("state code not one-hot");
    COV_EQ_WAIT: cover property (@(posedge clk) run.valid && best.valid && best.pri == run.pri);
    COV_TAIL: cover property (@(posedge clk) vec_valid && !vec_preempt && vec_num >= EPVU_IRQ_BASE);
    COV_PREEMPT: cover property (@(posedge clk) vec_valid && vec_preempt);
    COV_RELOC: cover property (@(posedge clk) base_q != EPVU_BASE_RESET);
    COV_NMI: cover property (@(posedge clk) vec_valid && vec_num == EPVU_EXC_NMI);
endmodule : epvu_core
`default_nettype wire

/* File: hdl/epvu_pkg.sv */
// Purpose: shared constants and types of the exception priority and vector unit
// Assumes: 44 interrupt slots, three-bit configurable priorities
// Notes:   priorities compare as signed four-bit values
package epvu_pkg;
    localparam int          EPVU_NUM_IRQ      = 44;
    localparam int          EPVU_NUM_EXC      = 60;
    localparam logic [5:0]  EPVU_IRQ_BASE     = 6'h10;
    localparam logic [31:0] EPVU_BASE_RESET   = 32'h0000_0000;
    localparam logic [31:0] EPVU_BASE_MIN     = 32'h0000_0100;
    localparam logic [31:0] EPVU_BASE_MAX     = 32'h3fff_ff00;
    localparam logic [43:0] EPVU_IRQ_PRESENT  = 44'h99f_ffff_c1ff;
    localparam logic [15:0] EPVU_SYS_PRESENT  = 16'hd87c;
    localparam logic [2:0]  EPVU_PRI_RESET    = 3'h0;
    localparam logic signed [3:0] EPVU_PRI_NMI   = -4'sd2;
    localparam logic signed [3:0] EPVU_PRI_HARD  = -4'sd1;
    localparam logic signed [3:0] EPVU_PRI_IDLE  = 4'sd7 + 4'sd0;
    localparam logic [5:0]  EPVU_EXC_NMI      = 6'h02;
    localparam logic [5:0]  EPVU_EXC_HARD     = 6'h03;

    typedef enum logic [2:0] {
        EPVU_IDLE   = 3'b001,
        EPVU_ENTER  = 3'b010,
        EPVU_ACTIVE = 3'b100
    } epvu_state_e;

    typedef struct packed {
        logic              valid;
        logic [5:0]        num;
        logic signed [3:0] pri;
    } epvu_cand_s;

    typedef struct packed {
        logic              take;
        logic              preempt;
        logic [5:0]        num;
        logic [31:0]       addr;
    } epvu_vec_s;
endpackage : epvu_pkg

/* File: tb/epvu_core_model.sv */
// Purpose: processor core side, accepts presented vectors
// Assumes: vec_valid falls two cycles after enter_ack
// Notes:   ack_delay sets prompt or slow acceptance
`timescale 1ns/1ps
`default_nettype none
module epvu_core_model
    import epvu_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       vec_valid,
    input  wire logic [3:0] ack_delay,
    output logic            enter_ack
);
    logic [3:0] cnt_q;
    logic [1:0] hold_q;
    // one ack per vector, none while the old one is draining
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enter_ack <= 1'b0;
            cnt_q     <= 4'h0;
            hold_q    <= 2'h0;
        end else begin
            enter_ack <= 1'b0;
            if (hold_q != 2'h0) begin
                hold_q <= hold_q - 2'h1;
            end else if (vec_valid) begin
                if (cnt_q >= ack_delay) begin
                    enter_ack <= 1'b1;
                    cnt_q     <= 4'h0;
                    hold_q    <= 2'h3;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule : epvu_core_model
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: self-checking bench of the exception priority and vector unit
// Assumes: core model acknowledges every vector
// Notes:   one task per scenario
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
    import epvu_pkg::*;
    logic clk = 0, resetn = 0, clk_en = 1, pri_wr = 0, base_wr = 0, base_wr_priv = 0, exc_return = 0, enter_ack;
    logic [43:0] irq_req = '0;
    logic [15:0] sys_req = '0;
    logic [5:0] pri_wr_num = '0, vec_num;
    logic [2:0] pri_wr_val = '0;
    logic [31:0] base_wr_val = '0, vec_addr, vbo;
    logic [59:0] pend_out, active_out;
    logic signed [3:0] run_pri;
    logic vec_valid, vec_preempt;
    logic [3:0] ack_delay = 4'h0;
    int n_fail = 0, n_tests = 0;
    epvu_core epvu_core_i (.clk(clk), .resetn(resetn), .clk_en(clk_en), .irq_req(irq_req), .sys_req(sys_req),
        .pri_wr(pri_wr), .pri_wr_num(pri_wr_num), .pri_wr_val(pri_wr_val), .base_wr(base_wr),
        .base_wr_priv(base_wr_priv), .base_wr_val(base_wr_val), .enter_ack(enter_ack), .exc_return(exc_return),
        .vec_valid(vec_valid), .vec_preempt(vec_preempt), .vec_num(vec_num), .vec_addr(vec_addr),
        .vector_base_offset_reg(vbo), .pend_out(pend_out), .active_out(active_out), .run_pri(run_pri));
    epvu_core_model epvu_core_model_i (.clk(clk), .resetn(resetn), .vec_valid(vec_valid),
        .ack_delay(ack_delay), .enter_ack(enter_ack));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic report_and_stop();
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    task automatic pulse(input logic [43:0] irqs, input logic [15:0] sys);
        irq_req <= irqs;
        sys_req <= sys;
        @(posedge clk);
        irq_req <= '0;
        sys_req <= '0;
    endtask : pulse
    task automatic setpri(input logic [5:0] n, input logic [2:0] v);
        pri_wr <= 1'b1; pri_wr_num <= n; pri_wr_val <= v;
        @(posedge clk);
        pri_wr <= 1'b0;
    endtask : setpri
    task automatic take(input logic [5:0] n, input logic [31:0] a, input logic pre);
        for (int i = 0; i < 20 && vec_valid !== 1'b1; i++) @(posedge clk);
        `CHK("vec_num", n, vec_num)
        `CHK("vec_addr", a, vec_addr)
        `CHK("vec word", 2'b00, vec_addr[1:0])
        `CHK("vec_preempt", pre, vec_preempt)
        for (int i = 0; i < 20 && active_out[n] !== 1'b1; i++) @(posedge clk);
        `CHK("active", 1'b1, active_out[n])
    endtask : take
    task automatic ret();
        exc_return <= 1'b1;
        @(posedge clk);
        exc_return <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : ret
    task automatic wbase(input logic [31:0] v, input logic priv);
        base_wr <= 1'b1; base_wr_val <= v; base_wr_priv <= priv;
        @(posedge clk);
        base_wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : wbase
    task automatic t_reset();
        `CHK("base", EPVU_BASE_RESET, vbo)
        `CHK("run_pri", EPVU_PRI_IDLE, run_pri)
        `CHK("pend", 60'h0, pend_out)
    endtask : t_reset
    task automatic t_order();
        pulse(44'h3, 16'h0);
        take(6'h10, 32'h40, 1'b0); ret(); take(6'h11, 32'h44, 1'b0); ret();
        setpri(6'h10, 3'h5); setpri(6'h11, 3'h2); ack_delay <= 4'h5;
        pulse(44'h3, 16'h0);
        take(6'h11, 32'h44, 1'b0); ret(); take(6'h10, 32'h40, 1'b0); ret();
        pulse(44'h1, 16'h0008);
        take(6'h03, 32'h0c, 1'b0); ret(); take(6'h10, 32'h40, 1'b0); ret();
    endtask : t_order
    task automatic t_preempt();
        setpri(6'h10, 3'h4); setpri(6'h11, 3'h4); setpri(6'h12, 3'h3); ack_delay <= 4'h0;
        pulse(44'h1, 16'h0);
        take(6'h10, 32'h40, 1'b0);
        pulse(44'h2, 16'h0);
        repeat (8) @(posedge clk);
        `CHK("no preempt", 1'b0, vec_valid)
        `CHK("pend equal", 1'b1, pend_out[17])
        pulse(44'h4, 16'h0);
        take(6'h12, 32'h48, 1'b1);
        `CHK("run_pri", 4'sd3, run_pri)
        pulse(44'h0, 16'h0004);
        take(6'h02, 32'h08, 1'b1);
        ret(); ret(); ret();
        take(6'h11, 32'h44, 1'b0); ret();
    endtask : t_preempt
    task automatic t_reserved();
        pulse(44'h200, 16'h0);
        repeat (6) @(posedge clk);
        `CHK("reserved pend", 1'b0, pend_out[25])
        `CHK("reserved vec", 1'b0, vec_valid)
        `CHK("run idle", EPVU_PRI_IDLE, run_pri)
        clk_en <= 1'b0;
        pulse(44'h1, 16'h0);
        repeat (2) @(posedge clk);
        clk_en <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK("frozen pend", 1'b0, pend_out[16])
        `CHK("frozen vec", 1'b0, vec_valid)
    endtask : t_reserved
    task automatic t_base();
        wbase(32'h0000_0200, 1'b0); `CHK("base unpriv", 32'h0, vbo)
        wbase(32'h4000_0000, 1'b1); `CHK("base high", 32'h0, vbo)
        wbase(32'h3fff_ff00, 1'b1); `CHK("base max", EPVU_BASE_MAX, vbo)
        wbase(32'h0000_01ff, 1'b1); `CHK("base align", EPVU_BASE_MIN, vbo)
        pulse(44'h800_0000_0000, 16'h0);
        take(6'h3b, 32'h0000_01ec, 1'b0); ret();
    endtask : t_base
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset(); t_order(); t_preempt(); t_reserved(); t_base();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
